// ### src/adc_ctrl_regs.svh
// Constants for the converter control and readout block
// How it works
// - Oversampling 1/4/16/64 gives 16 to 19 bits
// - Unipolar straight binary, pseudobipolar twos complement
// - Core delivers sixteen-bit raw results
// - Per-channel offset and gain corrections applied
// - Convert start honoured only in conversion mode
// - Convert start rising edge samples channel when idle; edges during a conversion are flagged as missed
// - Zeros shifted out until oversampled result ready
// - Autocycle ignores input, internal timer triggers conversions
// - Single lane uses primary output; dual/quad add lanes
// - Dual lane: busy/alert pin zero is lane one, the second data lane
// - Boost raises buffer current; set with enable
// - Readout uses four-wire SPI in mode three
// - Busy low once the oversampled result is ready, high at start
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

`define CHANNELS            8
`define CHAN_BITS           3
`define CORE_BITS           16
`define RESULT_BITS         19
`define FRAME_BITS          20
`define ACC_BITS            22
`define COUNT_BITS          7
`define GAIN_BITS           16
`define GAIN_UNITY_SHIFT    15
`define CORE_CODE_MAX       16'hffff
`define OSR_CODE_1          2'h0
`define OSR_CODE_4          2'h1
`define OSR_CODE_16         2'h2
`define OSR_CODE_64         2'h3
`define OSR_COUNT_1         7'h01
`define OSR_COUNT_4         7'h04
`define OSR_COUNT_16        7'h10
`define OSR_COUNT_64        7'h40
`define CLK_PERIOD_NS       10
`define AUTOCYCLE_PERIOD_NS 1000
`define AUTOCYCLE_CYCLES    (`AUTOCYCLE_PERIOD_NS / `CLK_PERIOD_NS)
`define TIMER_BITS          12

`endif

// ### src/adc_ctrl_pkg.sv
// Types and shared decoding for the converter control block
`include "adc_ctrl_regs.svh"
package adc_ctrl_pkg;
  typedef enum logic [1:0] {LANE_SINGLE, LANE_DUAL, LANE_QUAD} lane_mode_e;
  typedef enum logic {CONV_IDLE, CONV_BUSY} conv_state_e;

  // Number of core samples summed per result
  function automatic logic [`COUNT_BITS-1:0] osr_count(input logic [1:0] code);
    logic [`COUNT_BITS-1:0] n;
    n = `OSR_COUNT_1;
    case (code)
      `OSR_CODE_4:  n = `OSR_COUNT_4;
      `OSR_CODE_16: n = `OSR_COUNT_16;
      `OSR_CODE_64: n = `OSR_COUNT_64;
      default:      n = `OSR_COUNT_1;
    endcase
    return n;
  endfunction
endpackage

// ### src/adc_oversampler.sv
// Per-channel accumulate and decimate with resolution extension
`timescale 1ns/1ps
`default_nettype none
module adc_oversampler
  import adc_ctrl_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  input  wire logic                     sample_valid,
  input  wire logic [`CHAN_BITS-1:0]    channel,
  input  wire logic [1:0]               osr_code,
  input  wire logic [`CORE_BITS-1:0]    sample,
  output logic                          result_valid,
  output logic [`RESULT_BITS-1:0]       result,
  output logic [1:0]                    result_osr
);
  logic [`ACC_BITS-1:0]   acc_reg [`CHANNELS];
  logic [`COUNT_BITS-1:0] cnt_reg [`CHANNELS];
  logic [`ACC_BITS-1:0]   sum;
  logic [`COUNT_BITS-1:0] cnt_inc;
  logic                   last;
  logic [`ACC_BITS-1:0]   decimated;

  assign sum     = acc_reg[channel] + `ACC_BITS'(sample);
  assign cnt_inc = cnt_reg[channel] + `COUNT_BITS'(1);
  assign last    = (cnt_inc >= osr_count(osr_code));
  // Sum of 4^k samples shifted by k leaves 16+k bits
  assign decimated = sum >> osr_code;

  genvar g;
  generate
    for (g = 0; g < `CHANNELS; g++) begin : g_chan
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          acc_reg[g] <= '0;
          cnt_reg[g] <= '0;
        end else if (ce && sample_valid && channel == `CHAN_BITS'(g)) begin
          acc_reg[g] <= last ? '0 : sum;
          cnt_reg[g] <= last ? '0 : cnt_inc;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_valid <= 1'b0;
      result       <= '0;
      result_osr   <= `OSR_CODE_1;
    end else if (ce) begin
      result_valid <= sample_valid && last;
      if (sample_valid && last) begin
        result     <= decimated[`RESULT_BITS-1:0];
        result_osr <= osr_code;
      end
    end
  end
endmodule
`default_nettype wire

// ### src/adc_readout_shifter.sv
// SPI mode 3 result shifter over one, two or four data lanes
`timescale 1ns/1ps
`default_nettype none
module adc_readout_shifter
  import adc_ctrl_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  input  wire logic                   cs_b,
  input  wire logic                   sck,
  input  wire lane_mode_e             lane_mode,
  input  wire logic [`FRAME_BITS-1:0] load_word,
  output logic                        frame_start,
  output logic [3:0]                  lanes,
  output logic [3:0]                  lanes_oe
);
  logic                   cs_b_prev_reg;
  logic                   sck_prev_reg;
  logic [`FRAME_BITS-1:0] shift_reg;
  logic [`FRAME_BITS-1:0] shift_next;
  logic                   sck_fall;
  logic [3:0]             active_lanes;

  // MSB leaves on lane zero, the next bits on the higher lanes
  function automatic logic [3:0] lane_bits(input logic [3:0] top);
    return {top[0], top[1], top[2], top[3]};
  endfunction

  assign frame_start = cs_b_prev_reg && !cs_b;
  // Mode 3: clock idles high, data moves on the falling edge
  assign sck_fall    = sck_prev_reg && !sck && !cs_b;
  assign shift_next  = (lane_mode == LANE_QUAD) ? (shift_reg << 4) :
                       (lane_mode == LANE_DUAL) ? (shift_reg << 2) : (shift_reg << 1);
  assign active_lanes = (lane_mode == LANE_QUAD) ? 4'hf :
                        (lane_mode == LANE_DUAL) ? 4'h3 : 4'h1;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_b_prev_reg <= 1'b1;
      sck_prev_reg  <= 1'b1;
      shift_reg     <= '0;
      lanes         <= '0;
      lanes_oe      <= '0;
    end else if (ce) begin
      cs_b_prev_reg <= cs_b;
      sck_prev_reg  <= sck;
      if (frame_start) begin
        shift_reg <= load_word;
        lanes     <= lane_bits(load_word[`FRAME_BITS-1 -: 4]) & active_lanes;
      end else if (sck_fall) begin
        shift_reg <= shift_next;
        lanes     <= lane_bits(shift_next[`FRAME_BITS-1 -: 4]) & active_lanes;
      end
      lanes_oe <= cs_b ? 4'h0 : active_lanes;
    end
  end
endmodule
`default_nettype wire

// ### src/adc_ctrl_top.sv
// Convert triggering, correction, coding and readout of a multiplexed converter
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_top
  import adc_ctrl_pkg::*;
(
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  input  wire logic                             clk_en,
  input  wire logic                             conversion_mode,
  input  wire logic                             autocycle_en,
  input  wire logic                             convert_start_input,
  input  wire logic [`CHAN_BITS-1:0]            channel_sel,
  input  wire logic [2*`CHANNELS-1:0]           oversampling_ratio,
  input  wire logic [`CHANNELS-1:0]             bipolar_mode,
  input  wire logic [`CORE_BITS*`CHANNELS-1:0]  offset_cfg,
  input  wire logic [`GAIN_BITS*`CHANNELS-1:0]  gain_cfg,
  input  wire lane_mode_e                       lane_mode,
  input  wire logic                             ref_buffer_on,
  input  wire logic                             ref_buffer_passthrough,
  input  wire logic                             ref_buffer_high_current,
  input  wire logic                             core_done,
  input  wire logic [`CORE_BITS-1:0]            core_data,
  input  wire logic                             cs_b,
  input  wire logic                             sck,
  output logic                                  core_start,
  output logic [`CHAN_BITS-1:0]                 core_channel,
  output logic                                  busy,
  output logic                                  missed_trigger,
  output logic                                  serial_data_lane,
  output logic                                  serial_data_lane_oe,
  output logic                                  busy_alert_gpio_zero,
  output logic                                  busy_alert_gpio_zero_oe,
  output logic [1:0]                            upper_data_lanes,
  output logic [1:0]                            upper_data_lanes_oe,
  output logic                                  ref_buf_enable,
  output logic                                  ref_buf_bypass,
  output logic                                  ref_buf_boost
);
  // ----------
  // Reset release
  // ----------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ----------
  // Per-channel configuration lookup
  // ----------
  function automatic logic [1:0] chan_osr(input logic [`CHAN_BITS-1:0] ch,
                                          input logic [2*`CHANNELS-1:0] cfg);
    return cfg[2*ch +: 2];
  endfunction

  function automatic logic [15:0] chan_word(input logic [`CHAN_BITS-1:0] ch,
                                            input logic [16*`CHANNELS-1:0] cfg);
    return cfg[16*ch +: 16];
  endfunction

  // ----------
  // Convert start selection
  // ----------
  logic                   cnv_prev_reg;
  logic [`TIMER_BITS-1:0] timer_reg;
  logic [`TIMER_BITS-1:0] timer_next;
  logic                   timer_tick;
  logic                   cnv_rise;
  logic                   trigger;
  conv_state_e            state_reg;
  conv_state_e            state_next;

  assign cnv_rise   = convert_start_input && !cnv_prev_reg;
  assign timer_tick = (timer_reg == `TIMER_BITS'(`AUTOCYCLE_CYCLES - 1));
  assign timer_next = (!conversion_mode || !autocycle_en || timer_tick) ?
                      '0 : timer_reg + `TIMER_BITS'(1);
  // Register configuration mode drops every trigger; autocycle masks the pin
  assign trigger = conversion_mode &&
                   (autocycle_en ? timer_tick : cnv_rise);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnv_prev_reg <= 1'b0;
      timer_reg    <= '0;
    end else if (clk_en) begin
      cnv_prev_reg <= convert_start_input;
      timer_reg    <= timer_next;
    end
  end

  // ----------
  // Conversion sequencing
  // ----------
  logic                  start_now;
  logic                  missed_next;
  logic [`CHAN_BITS-1:0] active_ch_reg;

  // A trigger landing mid-conversion cannot be sampled; it is flagged instead
  assign start_now   = trigger && (state_reg == CONV_IDLE);
  assign missed_next = (trigger && state_reg == CONV_BUSY) ||
                       (missed_trigger && !start_now);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CONV_IDLE: begin
        if (start_now) begin
          state_next = CONV_BUSY;
        end
      end
      CONV_BUSY: begin
        if (core_done) begin
          state_next = CONV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg      <= CONV_IDLE;
      core_start     <= 1'b0;
      active_ch_reg  <= '0;
      missed_trigger <= 1'b0;
    end else if (clk_en) begin
      state_reg      <= state_next;
      core_start     <= start_now;
      missed_trigger <= missed_next;
      if (start_now) begin
        active_ch_reg <= channel_sel;
      end
    end
  end
  assign core_channel = active_ch_reg;

  // ----------
  // Offset and gain correction
  // ----------
  logic [`CHAN_BITS-1:0]    ch;
  logic [31:0]              gain_product;
  logic signed [18:0]       scaled;
  logic signed [18:0]       offset_ext;
  logic signed [18:0]       corrected;
  logic [`CORE_BITS-1:0]    corrected_sat;

  assign ch           = active_ch_reg;
  // Gain is unsigned with unity at the top bit; offset is signed in core LSBs
  assign gain_product = 32'(core_data) * 32'(chan_word(ch, gain_cfg));
  assign scaled       = $signed({2'b00, gain_product[`GAIN_UNITY_SHIFT +: 17]});
  assign offset_ext   = 19'($signed(chan_word(ch, offset_cfg)));
  assign corrected    = scaled + offset_ext;
  // Clip rather than wrap so a large correction cannot fold full scale to zero
  assign corrected_sat = corrected[18] ? '0 :
                         (corrected > 19'sd65535) ? `CORE_CODE_MAX :
                         corrected[`CORE_BITS-1:0];

  // ----------
  // Oversampling
  // ----------
  logic                    os_valid;
  logic [`RESULT_BITS-1:0] os_result;
  logic [1:0]              os_osr;

  adc_oversampler u_oversampler (
    .clk          (clk),
    .rst_n        (rst_n),
    .ce           (clk_en),
    .sample_valid (core_done && state_reg == CONV_BUSY),
    .channel      (ch),
    .osr_code     (chan_osr(ch, oversampling_ratio)),
    .sample       (corrected_sat),
    .result_valid (os_valid),
    .result       (os_result),
    .result_osr   (os_osr)
  );

  // -------------------------------------------------------------------------
  // Output coding and result holding
  // -------------------------------------------------------------------------
  logic [`RESULT_BITS-1:0] sign_bit;
  logic [`RESULT_BITS-1:0] coded;
  logic [`FRAME_BITS-1:0]  aligned;
  logic [`FRAME_BITS-1:0]  result_word_reg;
  logic                    fresh_reg;
  logic                    frame_start;
  logic [`FRAME_BITS-1:0]  load_word;

  // Result width is 16 + osr code; flipping its top bit gives twos complement
  assign sign_bit = `RESULT_BITS'(1) << (`CORE_BITS - 1 + os_osr);
  assign coded    = bipolar_mode[ch] ? (os_result ^ sign_bit) : os_result;
  assign aligned  = `FRAME_BITS'(coded) << (`FRAME_BITS - `CORE_BITS - os_osr);
  // Frames that start before a new result is ready carry zeros
  assign load_word = fresh_reg ? result_word_reg : '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_word_reg <= '0;
      fresh_reg       <= 1'b0;
    end else if (clk_en) begin
      if (os_valid) begin
        result_word_reg <= aligned;
      end
      // A result arriving with the frame start survives for the next frame
      fresh_reg <= os_valid || (fresh_reg && !frame_start);
    end
  end

  // -------------------------------------------------------------------------
  // Busy indicator
  // -------------------------------------------------------------------------
  // Held high across partial oversampling steps so the host reads only once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else if (clk_en) begin
      if (start_now) begin
        busy <= 1'b1;
      end else if (os_valid) begin
        busy <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------------
  // Serial readout lanes
  // -------------------------------------------------------------------------
  logic [3:0] lanes;
  logic [3:0] lanes_oe;
  logic       multi_lane;

  adc_readout_shifter u_shifter (
    .clk         (clk),
    .rst_n       (rst_n),
    .ce          (clk_en),
    .cs_b        (cs_b),
    .sck         (sck),
    .lane_mode   (lane_mode),
    .load_word   (load_word),
    .frame_start (frame_start),
    .lanes       (lanes),
    .lanes_oe    (lanes_oe)
  );

  assign multi_lane          = (lane_mode != LANE_SINGLE);
  assign serial_data_lane    = lanes[0];
  assign serial_data_lane_oe = lanes_oe[0];
  // Pin zero carries busy unless it is claimed as the second data lane
  assign busy_alert_gpio_zero    = multi_lane ? lanes[1] : busy;
  assign busy_alert_gpio_zero_oe = multi_lane ? lanes_oe[1] : 1'b1;
  assign upper_data_lanes        = lanes[3:2];
  assign upper_data_lanes_oe     = lanes_oe[3:2];

  // -------------------------------------------------------------------------
  // Reference buffer controls
  // -------------------------------------------------------------------------
  // Boost only matters while the buffer drives; passthrough follows its input alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_buf_enable <= 1'b0;
      ref_buf_bypass <= 1'b0;
      ref_buf_boost  <= 1'b0;
    end else if (clk_en) begin
      ref_buf_enable <= ref_buffer_on;
      ref_buf_bypass <= ref_buffer_passthrough;
      ref_buf_boost  <= ref_buffer_high_current && ref_buffer_on;
    end
  end
endmodule
`default_nettype wire

// ### verification/adc_core_model.sv
// Behavioural model of the analog core that answers convert requests
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_regs.svh"
module adc_core_model (
  input  wire logic                  clk,
  input  wire logic                  slow,
  input  wire logic                  core_start,
  input  wire logic [`CORE_BITS-1:0] raw_value,
  output logic                       core_done,
  output logic [`CORE_BITS-1:0]      core_data
);
  int wait_cnt = -1;

  initial core_done = 1'b0;
  initial core_data = 16'hffff;

  // Data toggles so a sample one cycle late never matches
  always @(posedge clk) begin
    core_done <= 1'b0;
    core_data <= ~core_data;
    if (core_start === 1'b1) begin
      wait_cnt <= slow ? 12 : 3;
    end else if (wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
    end else if (wait_cnt == 0) begin
      core_done <= 1'b1;
      core_data <= raw_value;
      wait_cnt  <= -1;
    end
  end
endmodule
`default_nettype wire

// ### verification/adc_ctrl_asserts.sv
// Concurrent checks on the ports of the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_regs.svh"
module adc_ctrl_asserts
  import adc_ctrl_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  rst_b,
  input wire logic                  clk_en,
  input wire logic                  conversion_mode,
  input wire logic                  autocycle_en,
  input wire logic                  convert_start_input,
  input wire logic [`CHAN_BITS-1:0] channel_sel,
  input wire lane_mode_e            lane_mode,
  input wire logic                  ref_buffer_on,
  input wire logic                  ref_buffer_passthrough,
  input wire logic                  ref_buffer_high_current,
  input wire logic                  core_done,
  input wire logic                  core_start,
  input wire logic [`CHAN_BITS-1:0] core_channel,
  input wire logic                  busy,
  input wire logic                  busy_alert_gpio_zero,
  input wire logic                  busy_alert_gpio_zero_oe,
  input wire logic [1:0]            upper_data_lanes_oe,
  input wire logic                  ref_buf_enable,
  input wire logic                  ref_buf_bypass,
  input wire logic                  ref_buf_boost
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------
  // Trigger and busy sequences
  // ----------
  sequence s_edge_taken;
    clk_en && conversion_mode && !autocycle_en && $rose(convert_start_input) && !busy
      && !core_start;
  endsequence

  sequence s_busy_drop;
    $fell(busy);
  endsequence

  a_start_on_edge: assert property (s_edge_taken |=> core_start && busy)
    else $error("input edge did not start a conversion");
  a_config_quiet: assert property (!conversion_mode |=> !core_start)
    else $error("conversion started in configuration mode");
  a_start_single: assert property (core_start |=> !core_start)
    else $error("start pulse longer than one cycle");
  a_channel_capture: assert property (core_start |-> core_channel == $past(channel_sel))
    else $error("converted channel differs from selection");
  a_busy_drop: assert property (s_busy_drop |-> $past(core_done, 2))
    else $error("busy fell without a finished conversion");
  a_single_busy: assert property (lane_mode == LANE_SINGLE && $past(lane_mode) == LANE_SINGLE
    |-> busy_alert_gpio_zero_oe && (busy_alert_gpio_zero == busy
    || busy_alert_gpio_zero == $past(busy)))
    else $error("pin zero does not show busy in single lane mode");
  a_upper_idle: assert property (lane_mode != LANE_QUAD && $past(lane_mode) != LANE_QUAD
    |-> upper_data_lanes_oe == 2'h0)
    else $error("upper lanes driven outside quad mode");
  a_boost_gate: assert property (ref_buf_boost == $past(ref_buffer_high_current
    & ref_buffer_on))
    else $error("boost output wrong");
  a_ref_follow: assert property ({ref_buf_enable, ref_buf_bypass}
    == $past({ref_buffer_on, ref_buffer_passthrough}))
    else $error("buffer enable or bypass wrong");
endmodule

bind adc_ctrl_top adc_ctrl_asserts CHK (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
  .conversion_mode(conversion_mode), .autocycle_en(autocycle_en),
  .convert_start_input(convert_start_input), .channel_sel(channel_sel), .lane_mode(lane_mode),
  .ref_buffer_on(ref_buffer_on), .ref_buffer_passthrough(ref_buffer_passthrough),
  .ref_buffer_high_current(ref_buffer_high_current), .core_done(core_done),
  .core_start(core_start), .core_channel(core_channel), .busy(busy),
  .busy_alert_gpio_zero(busy_alert_gpio_zero), .busy_alert_gpio_zero_oe(busy_alert_gpio_zero_oe),
  .upper_data_lanes_oe(upper_data_lanes_oe), .ref_buf_enable(ref_buf_enable),
  .ref_buf_bypass(ref_buf_bypass), .ref_buf_boost(ref_buf_boost));
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_regs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module testbench;
  import adc_ctrl_pkg::*;
  logic         clk = 1'b0;
  logic         rst_b = 1'b0;
  logic         conversion_mode = 1'b1;
  logic         autocycle_en = 1'b0;
  logic         convert_start_input = 1'b0;
  logic [2:0]   channel_sel = 3'h0;
  logic [15:0]  oversampling_ratio = 16'h0000;
  logic [7:0]   bipolar_mode = 8'h00;
  logic [127:0] offset_cfg = '0;
  logic [127:0] gain_cfg = {8{16'h8000}};
  lane_mode_e   lane_mode = LANE_SINGLE;
  logic         ref_buffer_on = 1'b0;
  logic         ref_buffer_passthrough = 1'b0;
  logic         ref_buffer_high_current = 1'b0;
  logic         cs_b = 1'b1;
  logic         sck = 1'b1;
  logic         slow = 1'b0;
  logic [15:0]  raw = 16'h0000;
  wire          core_done, core_start, busy, missed_trigger, serial_data_lane;
  wire          busy_alert_gpio_zero, busy_alert_gpio_zero_oe;
  wire          ref_buf_enable, ref_buf_bypass, ref_buf_boost;
  wire [15:0]   core_data;
  int           err_total = 0;
  int           checked = 0;
  int           starts = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (core_start === 1'b1) starts <= starts + 1;

  adc_ctrl_top DUT (.clk(clk), .rst_b(rst_b), .clk_en(1'b1), .conversion_mode(conversion_mode),
    .autocycle_en(autocycle_en), .convert_start_input(convert_start_input),
    .channel_sel(channel_sel), .oversampling_ratio(oversampling_ratio),
    .bipolar_mode(bipolar_mode), .offset_cfg(offset_cfg), .gain_cfg(gain_cfg),
    .lane_mode(lane_mode), .ref_buffer_on(ref_buffer_on),
    .ref_buffer_passthrough(ref_buffer_passthrough),
    .ref_buffer_high_current(ref_buffer_high_current), .core_done(core_done),
    .core_data(core_data), .cs_b(cs_b), .sck(sck), .core_start(core_start), .core_channel(),
    .busy(busy), .missed_trigger(missed_trigger), .serial_data_lane(serial_data_lane),
    .serial_data_lane_oe(), .busy_alert_gpio_zero(busy_alert_gpio_zero),
    .busy_alert_gpio_zero_oe(busy_alert_gpio_zero_oe), .upper_data_lanes(),
    .upper_data_lanes_oe(), .ref_buf_enable(ref_buf_enable), .ref_buf_bypass(ref_buf_bypass),
    .ref_buf_boost(ref_buf_boost));

  adc_core_model CORE (.clk(clk), .slow(slow), .core_start(core_start), .raw_value(raw),
    .core_done(core_done), .core_data(core_data));

  // ----------
  // Host side transfers
  // ----------
  task automatic conv(input logic [15:0] r);
    int n;
    raw = r;
    convert_start_input = 1'b1;
    n = 0;
    while (core_done !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK("core_done", 1'b1, core_done)
    convert_start_input = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // Frame after conversion, host samples on sck rise
  task automatic read(input int sh, output logic [19:0] w);
    w = 20'h00000;
    cs_b = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 20 / sh; i++) begin
      if (i > 0) begin
        sck = 1'b0;
        repeat (4) @(negedge clk);
        sck = 1'b1;
        repeat (4) @(negedge clk);
      end
      w = (sh == 1) ? {w[18:0], serial_data_lane} : {w[17:0], serial_data_lane,
        busy_alert_gpio_zero};
    end
    cs_b = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic pulse();
    // Periodic edges above min_cycle_period
    convert_start_input = 1'b1;
    repeat (10) @(negedge clk);
    convert_start_input = 1'b0;
    repeat (10) @(negedge clk);
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_ref();
    logic [5:0] tab [4];
    tab = '{6'h24, 6'h1a, 6'h2d, 6'h00};
    for (int k = 0; k < 4; k++) begin
      {ref_buffer_on, ref_buffer_passthrough, ref_buffer_high_current} = tab[k][5:3];
      repeat (2) @(negedge clk);
      `CHK("ref_outputs", tab[k][2:0], {ref_buf_enable, ref_buf_bypass, ref_buf_boost})
    end
    $display("ref done");
  endtask

  task automatic t_modes();
    int s0;
    logic [19:0] w;
    conversion_mode = 1'b0;
    s0 = starts;
    repeat (3) pulse();
    `CHK("config_ignored", s0, starts)
    conversion_mode = 1'b1;
    autocycle_en = 1'b1;
    s0 = starts;
    repeat (12) pulse();
    `CHK("autocycle_count", 1'b1, (starts - s0 >= 2) && (starts - s0 <= 3))
    autocycle_en = 1'b0;
    repeat (30) @(negedge clk);
    read(1, w);
    $display("modes done");
  endtask

  task automatic t_lanes();
    logic [19:0] w;
    channel_sel = 3'h1;
    conv(16'h1234);
    read(1, w);
    `CHK("single_frame", 20'h12340, w)
    read(1, w);
    `CHK("stale_frame", 20'h00000, w)
    lane_mode = LANE_DUAL;
    conv(16'ha5c3);
    read(2, w);
    `CHK("dual_frame", 20'ha5c30, w)
    lane_mode = LANE_SINGLE;
    $display("lanes done");
  endtask

  task automatic t_gain();
    logic [19:0] w;
    logic [63:0] tab [3];
    tab = '{64'h4000_0005_1000_0805, 64'h8000_ff9c_000a_0000, 64'hffff_0000_ffff_ffff};
    channel_sel = 3'h3;
    for (int k = 0; k < 3; k++) begin
      gain_cfg[63:48] = tab[k][63:48];
      offset_cfg[63:48] = tab[k][47:32];
      conv(tab[k][31:16]);
      read(1, w);
      `CHK("corrected", {tab[k][15:0], 4'h0}, w)
    end
    $display("gain done");
  endtask

  task automatic t_osr();
    logic [19:0] w;
    logic [21:0] sum;
    logic [18:0] v;
    channel_sel = 3'h2;
    for (int c = 0; c < 4; c++) begin
      oversampling_ratio[5:4] = c[1:0];
      bipolar_mode[2] = c[0];
      slow = c[1];
      sum = '0;
      for (int i = 0; i < (1 << (2 * c)); i++) begin
        conv(16'h4000 + 16'(i * 3));
        sum = sum + 22'(16'h4000 + i * 3);
        if (i == (1 << (2 * c)) - 2) begin
          read(1, w);
          `CHK("osr_zero", 20'h00000, w)
        end
      end
      v = 19'(sum >> c) & ((19'h1 << (16 + c)) - 19'h1);
      v[15 + c] = v[15 + c] ^ c[0];
      read(1, w);
      `CHK("osr_frame", 20'(v) << (4 - c), w)
    end
    $display("osr done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Run needs about 4k cycles
  initial begin
    #500000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("reset_state", 6'h01, {core_start, busy, missed_trigger, ref_buf_enable,
      ref_buf_boost, busy_alert_gpio_zero_oe})
    t_ref();
    t_modes();
    t_lanes();
    t_gain();
    t_osr();
    tally_and_finish();
  end
endmodule
`default_nettype wire
